//--- src/uartrp_consts.svh
// Constants for the serial register access port
`ifndef UARTRP_CONSTS_SVH
`define UARTRP_CONSTS_SVH

// System clock rate in Hz
`define UARTRP_CLK_HZ 100000000
// Selectable line rates in bit/s
`define UARTRP_BAUD_0 9600
`define UARTRP_BAUD_1 115200
`define UARTRP_BAUD_2 921600
`define UARTRP_BAUD_3 3000000
// Inter-byte timeout in milliseconds
`define UARTRP_TIMEOUT_MS 1000
// Character and datagram layout
`define UARTRP_DATA_BITS 8
`define UARTRP_FRAME_BYTES 3'h5
`define UARTRP_LAST_RX_BYTE 3'h4
`define UARTRP_FLAG_BIT 39
`define UARTRP_ADDR_HI 38
`define UARTRP_ADDR_LO 32
// Local register offsets
`define UARTRP_ADDR_CHIP_WORD 7'h00
`define UARTRP_ADDR_CHIP_SEL 7'h01
// Reset value of the identification selector
`define UARTRP_SEL_RESET 32'h0000_0000
// Selector codes for the identification words
`define UARTRP_SEL_TYPE 32'h0000_0000
`define UARTRP_SEL_VERSION 32'h0000_0001

`endif

//--- src/uartrp_pkg.sv
// Types shared by the serial register access port
package uartrp_pkg;

    // Line rate selection codes
    typedef enum logic [1:0] {
        UARTRP_BAUD_9600,
        UARTRP_BAUD_115200,
        UARTRP_BAUD_921600,
        UARTRP_BAUD_3000000
    } uartrp_baud_t;

    // Datagram handler states
    typedef enum logic [2:0] {
        PS_IDLE,
        PS_RECV,
        PS_ACCESS,
        PS_SEND,
        PS_WAIT
    } uartrp_proto_t;

    // Receiver states
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } uartrp_rx_t;

    // Transmitter states
    typedef enum logic {
        TX_IDLE,
        TX_RUN
    } uartrp_tx_t;

endpackage : uartrp_pkg

//--- src/uartrp_phy.sv
// Serial character receiver and transmitter, 1N8 framing
`timescale 1ns/10ps
`default_nettype none
`include "uartrp_consts.svh"

module uartrp_phy (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [15:0] bit_div,
    input wire logic serial_in,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_start,
    output logic tx_busy,
    output logic serial_out
);
    import uartrp_pkg::*;

    // Input synchroniser, first stage feeds only the second
    logic rx_s1_q;
    logic rx_s2_q;
    // Receiver state
    uartrp_rx_t rx_st_q, rx_st_d;
    logic [15:0] rx_cnt_q, rx_cnt_d;
    logic [2:0] rx_idx_q, rx_idx_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic rx_vld_q, rx_vld_d;
    // Transmitter state
    uartrp_tx_t tx_st_q, tx_st_d;
    logic [15:0] tx_cnt_q, tx_cnt_d;
    logic [3:0] tx_idx_q, tx_idx_d;
    logic [9:0] tx_sh_q, tx_sh_d;

    // Two-flop synchroniser on the serial input
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
        end
        else
        begin
            rx_s1_q <= serial_in;
            rx_s2_q <= rx_s1_q;
        end
    end

    // Receiver next state, samples each bit at its centre
    always_comb
    begin
        rx_st_d = rx_st_q;
        rx_cnt_d = rx_cnt_q;
        rx_idx_d = rx_idx_q;
        rx_sh_d = rx_sh_q;
        rx_vld_d = 1'b0;
        unique case (rx_st_q)
            RX_IDLE:
            begin
                // High line means an inactive port
                if (!rx_s2_q) // R09
                begin
                    rx_cnt_d = {1'b0, bit_div[15:1]}; // R13
                    rx_st_d = RX_START;
                end
            end
            RX_START:
            begin
                if (rx_cnt_q == 16'h0000)
                begin
                    // Glitch shorter than half a bit is dropped
                    if (!rx_s2_q)
                    begin
                        rx_cnt_d = bit_div - 16'h0001;
                        rx_idx_d = 3'h0;
                        rx_st_d = RX_DATA;
                    end
                    else
                    begin
                        rx_st_d = RX_IDLE;
                    end
                end
                else
                begin
                    rx_cnt_d = rx_cnt_q - 16'h0001;
                end
            end
            RX_DATA:
            begin
                if (rx_cnt_q == 16'h0000)
                begin
                    // LSB first, eight data bits
                    rx_sh_d = {rx_s2_q, rx_sh_q[7:1]}; // R01
                    rx_cnt_d = bit_div - 16'h0001;
                    rx_idx_d = rx_idx_q + 3'h1;
                    if (rx_idx_q == 3'h7)
                    begin
                        rx_st_d = RX_STOP;
                    end
                end
                else
                begin
                    rx_cnt_d = rx_cnt_q - 16'h0001;
                end
            end
            RX_STOP:
            begin
                if (rx_cnt_q == 16'h0000)
                begin
                    // Framing error discards the character
                    rx_vld_d = rx_s2_q; // R01
                    rx_st_d = RX_IDLE;
                end
                else
                begin
                    rx_cnt_d = rx_cnt_q - 16'h0001;
                end
            end
        endcase
    end

    // Receiver registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            rx_st_q <= RX_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_idx_q <= 3'h0;
            rx_sh_q <= 8'h00;
            rx_vld_q <= 1'b0;
        end
        else
        begin
            rx_st_q <= rx_st_d;
            rx_cnt_q <= rx_cnt_d;
            rx_idx_q <= rx_idx_d;
            rx_sh_q <= rx_sh_d;
            rx_vld_q <= rx_vld_d;
        end
    end

    assign rx_data = rx_sh_q;
    assign rx_valid = rx_vld_q;

    // Transmitter next state, start bit, data LSB first, stop bit
    always_comb
    begin
        tx_st_d = tx_st_q;
        tx_cnt_d = tx_cnt_q;
        tx_idx_d = tx_idx_q;
        tx_sh_d = tx_sh_q;
        unique case (tx_st_q)
            TX_IDLE:
            begin
                if (tx_start)
                begin
                    tx_sh_d = {1'b1, tx_data, 1'b0}; // R01
                    tx_cnt_d = bit_div - 16'h0001;
                    tx_idx_d = 4'h0;
                    tx_st_d = TX_RUN;
                end
            end
            TX_RUN:
            begin
                if (tx_cnt_q == 16'h0000)
                begin
                    // Shift in ones so the line idles high
                    tx_sh_d = {1'b1, tx_sh_q[9:1]};
                    tx_cnt_d = bit_div - 16'h0001;
                    tx_idx_d = tx_idx_q + 4'h1;
                    if (tx_idx_q == 4'h9)
                    begin
                        tx_st_d = TX_IDLE;
                    end
                end
                else
                begin
                    tx_cnt_d = tx_cnt_q - 16'h0001;
                end
            end
        endcase
    end

    // Transmitter registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            tx_st_q <= TX_IDLE;
            tx_cnt_q <= 16'h0000;
            tx_idx_q <= 4'h0;
            tx_sh_q <= 10'h3ff;
        end
        else
        begin
            tx_st_q <= tx_st_d;
            tx_cnt_q <= tx_cnt_d;
            tx_idx_q <= tx_idx_d;
            tx_sh_q <= tx_sh_d;
        end
    end

    assign tx_busy = (tx_st_q != TX_IDLE);
    assign serial_out = tx_sh_q[0];

endmodule : uartrp_phy

`default_nettype wire

//--- src/uartrp_top.sv
// Serial register access port: datagram handler and local registers
// Overview of operation
// (R01) Characters are 1N8, up to 3 Mbit/s
// (R02) Line rate is 9600 after reset; the divider here follows baud_sel from the first clock after reset
// (R03) Also 115200, 921600 and 3000000 bit/s
// (R04) Requests and replies are five bytes
// (R05) Flag bit, 7-bit address, 32-bit data MSB first
// (R06) Read request returns five-byte reply with data
// (R07) Selector at 0x01 picks word read at 0x00
// (R08) Over one second idle abandons partial datagram
// (R09) High receive line means inactive port
// (R10) Other registers reached through shared arbiter
// (R11) Host should mostly read, not overwrite
// (R12) Write stored after fifth byte only
// (R13) Divider sets bit time, centre sampling
`timescale 1ns/10ps
`default_nettype none
`include "uartrp_consts.svh"

module uartrp_top #(
    parameter int unsigned DIV_9600 = (`UARTRP_CLK_HZ + `UARTRP_BAUD_0 / 2) / `UARTRP_BAUD_0,
    parameter int unsigned DIV_115200 = (`UARTRP_CLK_HZ + `UARTRP_BAUD_1 / 2) / `UARTRP_BAUD_1,
    parameter int unsigned DIV_921600 = (`UARTRP_CLK_HZ + `UARTRP_BAUD_2 / 2) / `UARTRP_BAUD_2,
    parameter int unsigned DIV_3000000 = (`UARTRP_CLK_HZ + `UARTRP_BAUD_3 / 2) / `UARTRP_BAUD_3,
    parameter int unsigned TIMEOUT_CYC = `UARTRP_TIMEOUT_MS * (`UARTRP_CLK_HZ / 1000),
    // Identification words, values arbitrary
    parameter logic [31:0] CHIP_TYPE_WORD = 32'h0000_a5a5,
    parameter logic [31:0] CHIP_VERSION_WORD = 32'h0000_0101
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire uartrp_pkg::uartrp_baud_t baud_sel,
    input wire logic reg_port_serial_in,
    output logic reg_port_serial_out,
    output logic bus_req,
    output logic bus_we,
    output logic [6:0] bus_addr,
    output logic [31:0] bus_wdata,
    input wire logic bus_gnt,
    input wire logic [31:0] bus_rdata
);
    import uartrp_pkg::*;

    // Datagram handler state
    uartrp_proto_t st_q, st_d;
    logic [2:0] cnt_q, cnt_d;       // Bytes received or sent
    logic [39:0] frame_q, frame_d;  // Datagram shift register
    logic [31:0] tmo_q, tmo_d;      // Cycles since last byte
    logic [31:0] sel_q, sel_d;      // Identification selector
    logic [15:0] div_q, div_d;      // Active bit divider
    // Character layer handshakes
    logic [7:0] rx_data;
    logic rx_valid;
    logic [7:0] tx_data;
    logic tx_start;
    logic tx_busy;
    // Decoded request fields
    logic req_wr;
    logic [6:0] req_addr;
    logic [31:0] chip_word;

    assign req_wr = frame_q[`UARTRP_FLAG_BIT]; // R05
    assign req_addr = frame_q[`UARTRP_ADDR_HI:`UARTRP_ADDR_LO]; // R05

    // Character receiver and transmitter
    uartrp_phy u_phy (
        .clk_sys(clk_sys),
        .rst(rst),
        .bit_div(div_q),
        .serial_in(reg_port_serial_in),
        .rx_data(rx_data),
        .rx_valid(rx_valid),
        .tx_data(tx_data),
        .tx_start(tx_start),
        .tx_busy(tx_busy),
        .serial_out(reg_port_serial_out)
    );

    // Divider lookup from the line rate selection
    always_comb
    begin
        unique case (baud_sel)
            UARTRP_BAUD_9600: div_d = 16'(DIV_9600); // R02
            UARTRP_BAUD_115200: div_d = 16'(DIV_115200); // R03
            UARTRP_BAUD_921600: div_d = 16'(DIV_921600); // R03
            UARTRP_BAUD_3000000: div_d = 16'(DIV_3000000); // R03
        endcase
    end

    // Divider register, 9600 divider during reset, baud_sel divider from the next clock
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            div_q <= 16'(DIV_9600); // R02
        end
        else
        begin
            div_q <= div_d; // R13
        end
    end

    // Identification word picked by the selector
    always_comb
    begin
        unique case (sel_q)
            `UARTRP_SEL_TYPE: chip_word = CHIP_TYPE_WORD; // R07
            `UARTRP_SEL_VERSION: chip_word = CHIP_VERSION_WORD; // R07
            default: chip_word = 32'h0000_0000;
        endcase
    end

    // Datagram handler next state
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        frame_d = frame_q;
        tmo_d = tmo_q;
        sel_d = sel_q;
        bus_req = 1'b0;
        tx_start = 1'b0;
        tx_data = frame_q[39:32];
        unique case (st_q)
            PS_IDLE:
            begin
                // First byte opens a datagram
                if (rx_valid)
                begin
                    frame_d = {frame_q[31:0], rx_data};
                    cnt_d = 3'h1;
                    tmo_d = 32'h0000_0000;
                    st_d = PS_RECV;
                end
            end
            PS_RECV:
            begin
                if (rx_valid)
                begin
                    // Bytes arrive MSB first behind the address byte
                    frame_d = {frame_q[31:0], rx_data}; // R05
                    cnt_d = cnt_q + 3'h1;
                    tmo_d = 32'h0000_0000;
                    if (cnt_q == `UARTRP_LAST_RX_BYTE)
                    begin
                        st_d = PS_ACCESS; // R04
                    end
                end
                else if (tmo_q >= TIMEOUT_CYC)
                begin
                    // Partial datagram dropped, nothing written
                    st_d = PS_IDLE; // R08
                end
                else
                begin
                    tmo_d = tmo_q + 32'h0000_0001; // R08
                end
            end
            PS_ACCESS:
            begin
                // Flag cleared only on completion so bus_we stands until grant
                cnt_d = 3'h0;
                if (req_addr == `UARTRP_ADDR_CHIP_WORD)
                begin
                    // Read-only word, writes ignored
                    frame_d[31:0] = chip_word; // R07
                    frame_d[`UARTRP_FLAG_BIT] = 1'b0;
                    st_d = req_wr ? PS_IDLE : PS_SEND; // R06
                end
                else if (req_addr == `UARTRP_ADDR_CHIP_SEL)
                begin
                    if (req_wr)
                    begin
                        sel_d = frame_q[31:0]; // R12
                        st_d = PS_IDLE;
                    end
                    else
                    begin
                        frame_d[31:0] = sel_q; // R06
                        frame_d[`UARTRP_FLAG_BIT] = 1'b0;
                        st_d = PS_SEND;
                    end
                end
                else
                begin
                    // Hold request until the arbiter grants it
                    bus_req = 1'b1; // R10
                    if (bus_gnt)
                    begin
                        frame_d[31:0] = bus_rdata; // R06
                        frame_d[`UARTRP_FLAG_BIT] = 1'b0;
                        st_d = req_wr ? PS_IDLE : PS_SEND; // R12
                    end
                end
            end
            PS_SEND:
            begin
                if (cnt_q == `UARTRP_FRAME_BYTES)
                begin
                    // Return once the last character has left
                    if (!tx_busy)
                    begin
                        st_d = PS_IDLE;
                    end
                end
                else if (!tx_busy)
                begin
                    // Next reply byte, address byte first
                    tx_start = 1'b1; // R04
                    frame_d = {frame_q[31:0], 8'h00};
                    cnt_d = cnt_q + 3'h1;
                    st_d = PS_WAIT;
                end
            end
            PS_WAIT:
            begin
                // One cycle for the busy flag to rise
                st_d = PS_SEND;
            end
        endcase
    end

    // Datagram handler registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_q <= PS_IDLE;
            cnt_q <= 3'h0;
            frame_q <= 40'h00_0000_0000;
            tmo_q <= 32'h0000_0000;
            sel_q <= `UARTRP_SEL_RESET;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            frame_q <= frame_d;
            tmo_q <= tmo_d;
            sel_q <= sel_d;
        end
    end

    // Arbiter request fields straight from the datagram register
    assign bus_we = req_wr; // R12
    assign bus_addr = req_addr; // R10
    assign bus_wdata = frame_q[31:0];

endmodule : uartrp_top

`default_nettype wire

//--- dv/uartrp_chk.sv
// Port checker for the serial register access port
`timescale 1ns/10ps
`default_nettype none

module uartrp_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire uartrp_pkg::uartrp_baud_t baud_sel,
    input wire logic reg_port_serial_in,
    input wire logic reg_port_serial_out,
    input wire logic bus_req,
    input wire logic bus_we,
    input wire logic [6:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_gnt,
    input wire logic [31:0] bus_rdata
);
    import uartrp_pkg::*;

    // One clock domain, reset disables all checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Line idle high and bus quiet right after reset
    a_reset_idle_out: assert property ($fell(rst) |-> reg_port_serial_out && !bus_req && bus_addr == 7'h00)
        else $error("outputs not idle after reset");
    // Request and its qualifiers hold until grant
    a_req_holds_stable: assert property (bus_req && !bus_gnt |=>
        bus_req && $stable(bus_addr) && $stable(bus_we) && $stable(bus_wdata))
        else $error("arbiter request changed before grant");
    // Request drops after the grant cycle
    a_req_drops_after: assert property (bus_req && bus_gnt |=> !bus_req)
        else $error("arbiter request held after grant");
    // Local registers never go through the arbiter
    a_remote_addr_only: assert property (bus_req |-> bus_addr > 7'h01)
        else $error("local address sent to arbiter");
    // No reply on the line while an access is pending
    a_quiet_during_access: assert property (bus_req |-> reg_port_serial_out)
        else $error("transmit active during access");
    // Start bit spans at least eight clock cycles
    a_start_bit_len: assert property ($fell(reg_port_serial_out) |-> (!reg_port_serial_out) [*8])
        else $error("start bit too short");
    // Granted read starts its reply promptly
    a_read_reply_soon: assert property (bus_req && bus_gnt && !bus_we |-> ##[1:20] !reg_port_serial_out)
        else $error("no reply after granted read");
    // Granted write sends nothing back
    a_write_no_reply: assert property (bus_req && bus_gnt && bus_we |=> reg_port_serial_out [*8])
        else $error("reply after write");

    // Main scenarios reached
    c_remote_write: cover property (bus_req && bus_gnt && bus_we);
    c_remote_read: cover property (bus_req && bus_gnt && !bus_we);
    c_reply_start: cover property ($fell(reg_port_serial_out));
endmodule : uartrp_chk

bind uartrp_top uartrp_chk i_chk (
    .clk_sys(clk_sys),
    .rst(rst),
    .baud_sel(baud_sel),
    .reg_port_serial_in(reg_port_serial_in),
    .reg_port_serial_out(reg_port_serial_out),
    .bus_req(bus_req),
    .bus_we(bus_we),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_gnt(bus_gnt),
    .bus_rdata(bus_rdata)
);

`default_nettype wire

//--- dv/uartrp_host.sv
// Serial host model: sends characters, collects reply bytes
`timescale 1ns/10ps
`default_nettype none

module uartrp_host (
    input wire logic clk_sys,
    input wire logic [15:0] bit_cyc,
    input wire logic reg_port_serial_out,
    output var logic reg_port_serial_in
);
    logic [7:0] rx_q [$]; // Received reply bytes
    logic [7:0] rx_b; // Byte being assembled

    // Line rests high, as with a pull-up
    initial reg_port_serial_in = 1'b1;

    // One character: start, 8 data bits LSB first, stop
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        @(negedge clk_sys);
        for (int i = 0; i < 10; i++)
        begin
            reg_port_serial_in = fr[i];
            repeat (bit_cyc) @(negedge clk_sys);
        end
    endtask : send_byte

    // Receiver samples at bit centres; a bad stop bit yields unknown
    initial
    begin
        forever
        begin
            @(negedge reg_port_serial_out);
            repeat (bit_cyc / 2) @(posedge clk_sys);
            for (int i = 0; i < 8; i++)
            begin
                repeat (bit_cyc) @(posedge clk_sys);
                rx_b[i] = reg_port_serial_out;
            end
            repeat (bit_cyc) @(posedge clk_sys);
            rx_q.push_back(reg_port_serial_out ? rx_b : 8'hxx);
        end
    end
endmodule : uartrp_host

`default_nettype wire

//--- dv/test_uart_register_access_port.sv
// Testbench for the serial register access port
`timescale 1ns/10ps
`default_nettype none

module test_uart_register_access_port;
    import uartrp_pkg::*;

    localparam logic [31:0] TYPE_W = 32'h0000_a5a5; // Default type word, value arbitrary
    localparam logic [31:0] VER_W = 32'h0000_0101; // Default version word, value arbitrary
    // Bit times: two shortened, two at their rounded 100 MHz dividers
    localparam logic [15:0] DIVS [4] = '{16'h0010, 16'h000c, 16'h006d, 16'h0021};

    logic clk_sys, rst, bus_gnt, ser_in, ser_out, bus_req, bus_we, seen_we;
    uartrp_baud_t baud_sel;
    logic [6:0] bus_addr, seen_addr;
    logic [31:0] bus_wdata, bus_rdata, rdata_val, seen_wdata;
    logic [39:0] got;
    int bad_count, checks_done, wait_cnt, gnt_wait;

    uartrp_top #(.DIV_9600(16), .DIV_115200(12), .TIMEOUT_CYC(2000)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .baud_sel(baud_sel), .reg_port_serial_in(ser_in),
        .reg_port_serial_out(ser_out), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_gnt(bus_gnt), .bus_rdata(bus_rdata));

    uartrp_host i_host (.clk_sys(clk_sys), .bit_cyc(DIVS[baud_sel]), .reg_port_serial_out(ser_out),
        .reg_port_serial_in(ser_in));

    // Clock
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Arbiter stand-in: one-cycle grant after gnt_wait cycles
    always @(negedge clk_sys)
    begin
        if (bus_gnt)
            bus_gnt = 1'b0;
        else if (bus_req && wait_cnt == gnt_wait)
        begin
            bus_gnt = 1'b1;
            bus_rdata = rdata_val;
            {seen_we, seen_addr, seen_wdata} = {bus_we, bus_addr, bus_wdata};
            wait_cnt = 0;
        end
        else if (bus_req)
            wait_cnt++;
    end

    task automatic check(input logic [39:0] g, input logic [39:0] e);
        checks_done++;
        if (g !== e)
        begin
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
            bad_count++;
        end
    endtask : check

    // Whole datagram, flag and address byte first
    task automatic send(input logic [39:0] d);
        for (int i = 0; i < 5; i++)
            i_host.send_byte(d[39 - 8 * i -: 8]);
    endtask : send

    // Read: data bytes of the request are don't-care
    task automatic rd(input logic [6:0] a, input logic [31:0] e);
        int n;
        n = 0;
        send({1'b0, a, 32'h5a5a_5a5a});
        while (i_host.rx_q.size() < 5 && n < 20000)
        begin
            @(negedge clk_sys);
            n++;
        end
        got = 'x;
        if (i_host.rx_q.size() >= 5)
            for (int i = 0; i < 5; i++)
                got = {got[31:0], i_host.rx_q.pop_front()};
        check(got, {1'b0, a, e});
    endtask : rd

    // Write, then confirm silence on the reply line
    task automatic wr(input logic [6:0] a, input logic [31:0] v);
        send({1'b1, a, v});
        repeat (40 * DIVS[baud_sel]) @(negedge clk_sys);
        check(40'(i_host.rx_q.size()), 40'h0);
    endtask : wr

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    // Main sequence
    initial
    begin
        rst = 1'b1;
        baud_sel = UARTRP_BAUD_9600;
        bus_gnt = 1'b0;
        bus_rdata = 32'h0;
        rdata_val = 32'h0;
        gnt_wait = 0;
        wait_cnt = 0;
        repeat (16) @(negedge clk_sys);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        rd(7'h00, TYPE_W);
        rd(7'h01, 32'h0);
        wr(7'h01, 32'h0000_0001);
        rd(7'h00, VER_W);
        wr(7'h00, 32'hffff_ffff);
        rd(7'h00, VER_W);
        wr(7'h01, 32'h0000_0002);
        rd(7'h00, 32'h0000_0000);
        wr(7'h01, 32'h0000_0001);
        gnt_wait = 5;
        rdata_val = 32'h1234_5678;
        rd(7'h23, 32'h1234_5678);
        check({seen_we, seen_addr, 32'h0}, {1'b0, 7'h23, 32'h0});
        wr(7'h45, 32'hdead_beef);
        check({seen_we, seen_addr, seen_wdata}, {1'b1, 7'h45, 32'hdead_beef});
        // Partial write left to time out, then a clean read
        i_host.send_byte(8'h81);
        i_host.send_byte(8'h00);
        i_host.send_byte(8'h00);
        repeat (2500) @(negedge clk_sys);
        rd(7'h01, 32'h0000_0001);
        for (int s = 1; s < 4; s++)
        begin
            baud_sel = uartrp_baud_t'(s);
            repeat (4) @(negedge clk_sys);
            rd(7'h01, 32'h0000_0001);
        end
        end_sim();
    end

    // Watchdog well beyond the expected run
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        bad_count++;
        end_sim();
    end
endmodule : test_uart_register_access_port

`default_nettype wire
